// ==== logic/rbhc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] host may write the transmit buffer in every mode
// [R2] transmit command sends whole buffer, or preset count, on chosen channel and rate
// [R3] received packet: size header gives byte count, or preset count in other subroutine
// [R4] interrupt goes high after a received packet is stored
// [R5] host can read receive buffer and received byte count
// [R6] interrupt clear command from host drops the interrupt
// [R7] calibration result lands in the 4-bit oscillator tune field
// [R8] config memory readable and writable in standby
// [R9] init mode loads config defaults, then raises interrupt
// [R10] serial link works at any rate up to 10MHz; the sampled edges here need SCK below a quarter of the 10MHz CLOCK
// [R11] power-on reset clears program and config memory
// [R12] mask in config memory selects which events drive the interrupt
// [R13] rom subroutines copied to program memory and started only on host request
// [R14] simple subroutine transmits then returns to standby, oscillator kept on
// [R15] receive subroutines put synthesizer in receive and enable receiver
// [R16] slave select is active high
// [R17] chip enable low holds the device in reset and power down
// [R18] interrupt stays high until cleared by command or reset; here it also drops when the host clears the event's bit in the mask
module rbhc_top import rbhc_pkg::*; (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic ENABLE,
	input wire logic SS,
	input wire logic SCK,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	output logic IRQ,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	output logic CAL_START,
	input wire logic CAL_DONE,
	input wire logic [3:0] CAL_CODE,
	output logic OSC_ON,
	output logic SYNTH_RX,
	output logic RX_ENABLE,
	output logic [7:0] CHANNEL,
	output logic [7:0] RATE,
	output logic [3:0] TUNE
);
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic run;
	logic ss_on;
	logic sck_s;
	logic mosi_s;
	logic sck_prev;
	logic sck_rise;
	logic sck_fall;

	logic [2:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic first;
	logic [3:0] op;
	logic [3:0] addr;
	logic byte_done;
	logic data_byte;
	logic [7:0] spi_byte;
	logic [3:0] cur_op;
	logic [3:0] rd_addr;
	logic [7:0] reply;

	logic cmd_hit;
	logic cmd_transmit;
	logic cmd_clr;
	logic cmd_standby;
	logic cmd_load;
	logic tx_start;

	rbhc_state_t state;
	logic [2:0] active_sub;
	logic [3:0] seq;
	logic [7:0] cfg_mem [MEM_WORDS];
	logic [7:0] prg_mem [MEM_WORDS];

	logic tx_push;
	logic tx_in_ready;
	logic tx_out_valid;
	logic [7:0] tx_out_data;
	logic tx_pop;
	logic tx_slot;
	logic tx_more;
	logic tx_done;
	logic [7:0] tx_left;
	logic tx_overrun;

	logic rx_accept;
	logic rx_store;
	logic rx_idle;
	logic rx_done;
	logic rx_pop;
	logic rx_out_valid;
	logic [7:0] rx_out_data;
	logic [FIFO_LVL_W-1:0] rx_level;
	logic [7:0] rx_target;
	logic [7:0] rx_byte_count;
	logic [7:0] cnt_base;
	logic [7:0] target_now;
	logic [7:0] next_count;

	logic init_done;
	logic cal_done;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] irq_status;

	// pins come from the host's domain
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			sck_prev <= 1'b0;
		end else begin
			sync_a <= {ENABLE, SS, SCK, MOSI};
			sync_b <= sync_a;
			sck_prev <= sync_b[1];
		end
	end

	assign run = sync_b[3]; // see [R17]
	assign ss_on = sync_b[2]; // see [R16]
	assign sck_s = sync_b[1];
	assign mosi_s = sync_b[0];
	// edges are found by sampling, so the serial clock must stay below a quarter of CLOCK
	assign sck_rise = sck_s & ~sck_prev; // see [R10]
	assign sck_fall = ~sck_s & sck_prev;

	assign spi_byte = {shift_in[6:0], mosi_s};
	assign byte_done = run & ss_on & sck_rise & (bit_cnt == 3'h7);
	assign data_byte = byte_done & ~first;
	assign cur_op = first ? spi_byte[7:4] : op;
	assign rd_addr = first ? spi_byte[3:0] : addr + 4'h1;

	assign cmd_hit = byte_done & first & (spi_byte[7:4] == OP_CMD);
	assign cmd_transmit = cmd_hit & (spi_byte[3:0] == CMD_TRANSMIT);
	assign cmd_clr = cmd_hit & (spi_byte[3:0] == CMD_CLR_IRQ);
	assign cmd_standby = cmd_hit & (spi_byte[3:0] == CMD_STANDBY);
	assign cmd_load = cmd_hit & spi_byte[CMD_LOAD_BIT];

	always_comb begin
		reply = 8'h00;
		if (cur_op == OP_CFG_RD) begin
			if (state == ST_STANDBY) begin
				reply = cfg_mem[rd_addr]; // see [R8]
			end
		end else if (cur_op == OP_PRG_RD) begin
			reply = prg_mem[rd_addr];
		end else if (cur_op == OP_RXB_RD) begin
			reply = rx_out_valid ? rx_out_data : 8'h00; // see [R5]
		end else if (cur_op == OP_RXCNT_RD) begin
			reply = rx_byte_count; // see [R5]
		end else if (cur_op == OP_STAT_RD) begin
			reply = {3'h0, tx_overrun, irq_status};
		end
	end

	// mode 0 framing: sample on rising, shift out on falling
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			bit_cnt <= 3'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			first <= 1'b1;
			op <= 4'h0;
			addr <= 4'h0;
			MISO <= 1'b0;
			MISO_OE <= 1'b0;
		end else begin
			MISO_OE <= run & ss_on;
			if (!run || !ss_on) begin
				bit_cnt <= 3'h0;
				first <= 1'b1;
				MISO <= 1'b0;
			end else begin
				if (sck_rise) begin
					shift_in <= spi_byte;
					bit_cnt <= bit_cnt + 3'h1;
				end
				if (byte_done) begin
					first <= 1'b0;
					shift_out <= reply;
					addr <= rd_addr;
					if (first) begin
						op <= spi_byte[7:4];
					end
				end else if (sck_fall) begin
					MISO <= shift_out[7];
					shift_out <= {shift_out[6:0], 1'b0};
				end
			end
		end
	end

	assign tx_start = cmd_transmit & ((state == ST_RX) | (state == ST_STANDBY && active_sub == SUB_SIMPLE));

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state <= ST_STANDBY;
			active_sub <= SUB_INIT;
			seq <= 4'h0;
			OSC_ON <= 1'b0;
			CAL_START <= 1'b0;
		end else if (!run) begin
			state <= ST_STANDBY; // see [R17]
			active_sub <= SUB_INIT;
			seq <= 4'h0;
			OSC_ON <= 1'b0;
			CAL_START <= 1'b0;
		end else begin
			CAL_START <= 1'b0;
			case (state)
				ST_STANDBY: begin
					if (cmd_load) begin
						state <= ST_COPY; // see [R13]
						seq <= 4'h0;
						active_sub <= spi_byte[2:0];
					end else if (tx_start) begin
						state <= ST_TX;
					end
				end
				ST_COPY: begin
					seq <= seq + 4'h1;
					if (seq == 4'hf) begin
						seq <= 4'h0;
						// the copied image, not the command, decides what runs
						active_sub <= prg_mem[0][2:0]; // see [R13]
						case (prg_mem[0][2:0])
							SUB_INIT: state <= ST_INIT;
							SUB_CAL: begin
								state <= ST_CAL;
								CAL_START <= 1'b1;
							end
							SUB_SIMPLE: begin
								state <= ST_STANDBY;
								OSC_ON <= 1'b1;
							end
							SUB_RX_HDR, SUB_RX_CNT: begin
								state <= ST_RX; // see [R15]
								OSC_ON <= 1'b1;
							end
							default: state <= ST_STANDBY;
						endcase
					end
				end
				ST_INIT: begin
					seq <= seq + 4'h1;
					if (seq == 4'hf) begin
						state <= ST_STANDBY;
					end
				end
				ST_CAL: begin
					if (CAL_DONE) begin
						state <= ST_STANDBY;
					end
				end
				ST_TX: begin
					if (tx_done) begin
						// oscillator stays running so the next send starts fast
						state <= (active_sub == SUB_SIMPLE) ? ST_STANDBY : ST_RX; // see [R14]
					end
				end
				ST_RX: begin
					if (cmd_load) begin
						state <= ST_COPY;
						seq <= 4'h0;
						active_sub <= spi_byte[2:0];
					end else if (tx_start) begin
						state <= ST_TX;
					end else if (cmd_standby) begin
						state <= ST_STANDBY;
						OSC_ON <= 1'b0;
					end
				end
				default: state <= ST_STANDBY;
			endcase
		end
	end

	assign init_done = (state == ST_INIT) & (seq == 4'hf);
	assign cal_done = (state == ST_CAL) & CAL_DONE;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				cfg_mem[i] <= 8'h00; // see [R11]
			end
		end else if (!run) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				cfg_mem[i] <= 8'h00;
			end
		end else begin
			if (state == ST_INIT) begin
				cfg_mem[seq] <= rbhc_cfg_default(seq); // see [R9]
			end else if (data_byte && op == OP_CFG_WR && state == ST_STANDBY) begin
				cfg_mem[addr] <= spi_byte; // see [R8]
			end
			if (cal_done) begin
				cfg_mem[CFG_TUNE][TUNE_MSB:TUNE_LSB] <= CAL_CODE; // see [R7]
			end
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				prg_mem[i] <= 8'h00; // see [R11]
			end
		end else if (!run) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				prg_mem[i] <= 8'h00;
			end
		end else if (state == ST_COPY) begin
			prg_mem[seq] <= rbhc_rom_byte(active_sub, seq); // see [R13]
		end else if (data_byte && op == OP_PRG_WR && state == ST_STANDBY) begin
			prg_mem[addr] <= spi_byte;
		end
	end

	// transmit path
	assign tx_push = data_byte & (op == OP_TXB_WR); // see [R1]
	assign tx_more = ~cfg_mem[CFG_PAYLOAD][PAY_TX_PRESET] | (tx_left != 8'h00); // see [R2]
	assign tx_slot = (state == ST_TX) & (~TX_VALID | TX_READY);
	assign tx_pop = tx_slot & tx_out_valid & tx_more;
	assign tx_done = tx_slot & ~(tx_out_valid & tx_more);

	rbhc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(CLOCK),
		.nrst(NRST),
		.clr(~run),
		.in_valid(tx_push),
		.in_ready(tx_in_ready),
		.in_data(spi_byte),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data),
		.level()
	);

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			tx_left <= 8'h00;
			tx_overrun <= 1'b0;
		end else if (!run) begin
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			tx_left <= 8'h00;
			tx_overrun <= 1'b0;
		end else begin
			if (tx_start) begin
				tx_left <= cfg_mem[CFG_TX_COUNT]; // see [R2]
			end else if (tx_pop) begin
				tx_left <= tx_left - 8'h01;
			end
			if (tx_slot) begin
				TX_VALID <= tx_pop;
				if (tx_pop) begin
					TX_DATA <= tx_out_data;
				end
			end
			// the serial link cannot stall, so a byte into a full buffer is lost and flagged
			if (tx_push && !tx_in_ready) begin
				tx_overrun <= 1'b1;
			end else if (cmd_clr) begin
				tx_overrun <= 1'b0;
			end
		end
	end

	// receive path
	assign rx_accept = RX_VALID & RX_READY;
	assign rx_store = rx_accept & ~(rx_idle & (active_sub == SUB_RX_HDR)); // see [R3]
	assign cnt_base = rx_idle ? 8'h00 : rx_byte_count;
	assign target_now = !rx_idle ? rx_target : (active_sub == SUB_RX_HDR) ? RX_DATA : cfg_mem[CFG_RX_COUNT]; // see [R3]
	assign next_count = rx_store ? cnt_base + 8'h01 : cnt_base;
	assign rx_done = rx_accept & (next_count >= target_now);
	assign rx_pop = byte_done & (cur_op == OP_RXB_RD) & rx_out_valid;

	rbhc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk(CLOCK),
		.nrst(NRST),
		.clr(~run),
		.in_valid(rx_store),
		.in_ready(),
		.in_data(RX_DATA),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data),
		.level(rx_level)
	);

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			RX_READY <= 1'b0;
			rx_idle <= 1'b1;
			rx_target <= 8'h00;
			rx_byte_count <= 8'h00;
		end else if (!run) begin
			RX_READY <= 1'b0;
			rx_idle <= 1'b1;
			rx_target <= 8'h00;
			rx_byte_count <= 8'h00;
		end else begin
			// one idle cycle after each byte keeps the level check exact despite the register
			RX_READY <= (state == ST_RX) & ~rx_accept & (rx_level <= FIFO_LVL_W'(FIFO_DEPTH - 2));
			if (state != ST_RX) begin
				rx_idle <= 1'b1;
			end else if (rx_accept) begin
				rx_byte_count <= next_count;
				rx_target <= target_now;
				rx_idle <= rx_done;
			end
		end
	end

	// events and interrupt
	assign events = {init_done, cal_done, rx_done, tx_done};

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			irq_status <= '0;
			IRQ <= 1'b0;
		end else if (!run) begin
			irq_status <= '0;
			IRQ <= 1'b0;
		end else begin
			// a new event in the clearing cycle survives the clear
			irq_status <= (cmd_clr ? '0 : irq_status) | events; // see [R6] see [R18] see [R4] see [R9]
			IRQ <= |(irq_status & cfg_mem[CFG_IRQ_MASK][EV_W-1:0]); // see [R12]
		end
	end

	// radio control straight from registers
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			SYNTH_RX <= 1'b0;
			RX_ENABLE <= 1'b0;
			CHANNEL <= 8'h00;
			RATE <= 8'h00;
			TUNE <= 4'h0;
		end else begin
			// drops with the oscillator on standby, never a cycle after it
			SYNTH_RX <= run & (state == ST_RX) & ~cmd_standby; // see [R15]
			RX_ENABLE <= run & (state == ST_RX) & ~cmd_standby;
			CHANNEL <= cfg_mem[CFG_CHANNEL];
			RATE <= cfg_mem[CFG_RATE];
			TUNE <= cfg_mem[CFG_TUNE][TUNE_MSB:TUNE_LSB];
		end
	end
endmodule
`default_nettype wire

// ==== logic/rbhc_pkg.sv ====
`default_nettype none
package rbhc_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = 4;
	localparam int MEM_WORDS = 16;
	localparam int ADDR_W = 4;
	localparam int EV_W = 4;

	// serial link figures
	localparam int SCK_MAX_KHZ = 10000;
	localparam int CLOCK_KHZ = 10000;

	// first byte of a transfer: opcode in [7:4], address or command in [3:0]
	localparam logic [3:0] OP_CFG_WR = 4'h1;
	localparam logic [3:0] OP_CFG_RD = 4'h2;
	localparam logic [3:0] OP_PRG_WR = 4'h3;
	localparam logic [3:0] OP_PRG_RD = 4'h4;
	localparam logic [3:0] OP_TXB_WR = 4'h5;
	localparam logic [3:0] OP_RXB_RD = 4'h6;
	localparam logic [3:0] OP_RXCNT_RD = 4'h7;
	localparam logic [3:0] OP_CMD = 4'h8;
	localparam logic [3:0] OP_STAT_RD = 4'h9;

	localparam logic [3:0] CMD_TRANSMIT = 4'h0;
	localparam logic [3:0] CMD_CLR_IRQ = 4'h1;
	localparam logic [3:0] CMD_STANDBY = 4'h2;
	localparam int CMD_LOAD_BIT = 3;

	// subroutine numbers held in the rom
	localparam logic [2:0] SUB_INIT = 3'h0;
	localparam logic [2:0] SUB_CAL = 3'h1;
	localparam logic [2:0] SUB_SIMPLE = 3'h2;
	localparam logic [2:0] SUB_RX_HDR = 3'h3;
	localparam logic [2:0] SUB_RX_CNT = 3'h4;

	// config memory layout
	localparam logic [3:0] CFG_IRQ_MASK = 4'h0;
	localparam logic [3:0] CFG_CHANNEL = 4'h1;
	localparam logic [3:0] CFG_RATE = 4'h2;
	localparam logic [3:0] CFG_PAYLOAD = 4'h3;
	localparam logic [3:0] CFG_TX_COUNT = 4'h4;
	localparam logic [3:0] CFG_RX_COUNT = 4'h5;
	localparam logic [3:0] CFG_TUNE = 4'h6;
	localparam int PAY_TX_PRESET = 0;
	localparam int TUNE_LSB = 0;
	localparam int TUNE_MSB = 3;

	localparam logic [7:0] DEF_IRQ_MASK = 8'h0f;
	localparam logic [7:0] DEF_TX_COUNT = 8'h08;
	localparam logic [7:0] DEF_RX_COUNT = 8'h08;

	// event bits in the interrupt status
	localparam int EV_SENT = 0;
	localparam int EV_RECV = 1;
	localparam int EV_CAL = 2;
	localparam int EV_INIT = 3;

	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_COPY = 3'b001,
		ST_INIT = 3'b010,
		ST_CAL = 3'b011,
		ST_TX = 3'b100,
		ST_RX = 3'b101
	} rbhc_state_t;

	function automatic logic [7:0] rbhc_cfg_default(input logic [3:0] idx);
		case (idx)
			CFG_IRQ_MASK: return DEF_IRQ_MASK;
			CFG_TX_COUNT: return DEF_TX_COUNT;
			CFG_RX_COUNT: return DEF_RX_COUNT;
			default: return 8'h00;
		endcase
	endfunction

	// word 0 of every image names the subroutine, the rest is its body
	function automatic logic [7:0] rbhc_rom_byte(input logic [2:0] sub, input logic [3:0] idx);
		if (idx == 4'h0) begin
			return {5'h00, sub};
		end
		return {1'b0, sub, idx};
	endfunction
endpackage
`default_nettype wire

// ==== logic/rbhc_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
// depth must be a power of two, the pointers wrap freely
module rbhc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = level != (AW+1)'(DEPTH);
	assign out_valid = level != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			case ({push, pop})
				2'b10: level <= level + 1'b1;
				2'b01: level <= level - 1'b1;
				default: level <= level;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verification/rbhc_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module rbhc_sva (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic ENABLE,
	input wire logic SS,
	input wire logic MISO,
	input wire logic MISO_OE,
	input wire logic IRQ,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire logic CAL_START,
	input wire logic CAL_DONE,
	input wire logic [3:0] CAL_CODE,
	input wire logic OSC_ON,
	input wire logic SYNTH_RX,
	input wire logic RX_ENABLE,
	input wire logic [3:0] TUNE
);
	logic [5:0] sel_gap;
	logic cal_wait;
	logic [3:0] code_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// an interrupt may only drop shortly after host traffic or chip disable
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			sel_gap <= 6'h00;
		end else if (SS || !ENABLE) begin
			sel_gap <= 6'h00;
		end else if (sel_gap != 6'h3f) begin
			sel_gap <= sel_gap + 6'h01;
		end
	end
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			cal_wait <= 1'b0;
		end else begin
			cal_wait <= ENABLE && (CAL_START || (cal_wait && !CAL_DONE));
		end
	end
	// no reset needed, only read after a capture
	always_ff @(posedge CLOCK) begin
		if (cal_wait && CAL_DONE) begin
			code_q <= CAL_CODE;
		end
	end
	property p_sel_idle; (!SS) [*5] |-> !MISO_OE && !MISO; endproperty
	a_sel_idle: assert property (p_sel_idle) else $error("miso driven while deselected");
	property p_sel_drive; (SS && ENABLE) [*5] |-> MISO_OE; endproperty
	a_sel_drive: assert property (p_sel_drive) else $error("miso not driven while selected");
	property p_rx_pair; SYNTH_RX == RX_ENABLE; endproperty
	a_rx_pair: assert property (p_rx_pair) else $error("receiver and synthesizer disagree");
	property p_rx_osc; SYNTH_RX |-> OSC_ON; endproperty
	a_rx_osc: assert property (p_rx_osc) else $error("receive without oscillator");
	property p_off; (!ENABLE) [*6] |-> !IRQ && !OSC_ON && !SYNTH_RX && !TX_VALID && TUNE == 4'h0; endproperty
	a_off: assert property (p_off) else $error("activity while chip disabled");
	property p_irq_hold; $fell(IRQ) |-> sel_gap < 6'd16; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a clear");
	property p_tx_hold;
		TX_VALID && !TX_READY && ENABLE && $past(ENABLE) && $past(ENABLE, 2) |=> TX_VALID && $stable(TX_DATA);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit byte changed while stalled");
	property p_cal_pulse; CAL_START |=> !CAL_START; endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start longer than a cycle");
	property p_tune; cal_wait && CAL_DONE && ENABLE |-> ##[2:4] TUNE == code_q; endproperty
	a_tune: assert property (p_tune) else $error("tune code not taken from calibration");
	c_tx: cover property (TX_VALID && TX_READY);
	c_irq: cover property ($rose(IRQ));
	c_cal: cover property (cal_wait && CAL_DONE);
endmodule
bind rbhc_top rbhc_sva rbhc_sva_i (
	.CLOCK(CLOCK), .NRST(NRST), .ENABLE(ENABLE), .SS(SS), .MISO(MISO), .MISO_OE(MISO_OE), .IRQ(IRQ),
	.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .CAL_START(CAL_START), .CAL_DONE(CAL_DONE),
	.CAL_CODE(CAL_CODE), .OSC_ON(OSC_ON), .SYNTH_RX(SYNTH_RX), .RX_ENABLE(RX_ENABLE), .TUNE(TUNE)
);
`default_nettype wire

// ==== verification/rbhc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rbhc_host_model (
	output logic ss,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	logic [7:0] rsp[$];
	initial begin
		ss = 1'b0;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// mode 0; reply read late in the high phase, where it has settled after the sync lag
	task automatic put_byte(input logic [7:0] tx);
		logic [7:0] rx;
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#400 sck = 1'b1; // 800 ns period
			#390 rx[i] = miso;
			#10 sck = 1'b0;
		end
		rsp.push_back(rx);
	endtask
	// command byte, then n data bytes counting up from first
	task automatic frame(input logic [7:0] cmd, input logic [7:0] first, input int n);
		rsp = {};
		#170 ss = 1'b1; // select is active high
		put_byte(cmd);
		for (int k = 0; k < n; k++) begin
			put_byte(first + 8'(k));
		end
		#400 ss = 1'b0;
		mosi = ~mosi; // released line keeps no stale level
	endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; $display("ERROR %s expected %h got %h", what, exp, got); end end
module testbench import rbhc_pkg::*;;
	logic CLOCK, NRST, ENABLE, SS, SCK, MOSI, MISO, MISO_OE, IRQ, TX_VALID, TX_READY, RX_VALID, RX_READY;
	logic CAL_START, CAL_DONE, OSC_ON, SYNTH_RX, RX_ENABLE;
	logic [7:0] TX_DATA, RX_DATA, CHANNEL, RATE;
	logic [3:0] CAL_CODE, TUNE;
	logic [7:0] resp[$];
	logic [7:0] got[$];
	int errors = 0;
	int n_checks = 0;
	rbhc_top rbhc_top_i (
		.CLOCK(CLOCK), .NRST(NRST), .ENABLE(ENABLE), .SS(SS), .SCK(SCK), .MOSI(MOSI), .MISO(MISO),
		.MISO_OE(MISO_OE), .IRQ(IRQ), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .CAL_START(CAL_START),
		.CAL_DONE(CAL_DONE), .CAL_CODE(CAL_CODE), .OSC_ON(OSC_ON), .SYNTH_RX(SYNTH_RX),
		.RX_ENABLE(RX_ENABLE), .CHANNEL(CHANNEL), .RATE(RATE), .TUNE(TUNE)
	);
	rbhc_host_model rbhc_host_model_i (.ss(SS), .sck(SCK), .mosi(MOSI), .miso(MISO));
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic spi(input logic [7:0] cmd, input logic [7:0] first, input int n);
		rbhc_host_model_i.frame(cmd, first, n);
		resp = rbhc_host_model_i.rsp;
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
	endtask
	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 300 && IRQ !== lvl; i++) @(negedge CLOCK);
		`CHK("irq", lvl, IRQ);
	endtask
	task automatic put_rx(input logic [7:0] b);
		@(posedge CLOCK);
		RX_DATA <= b;
		RX_VALID <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge CLOCK);
			if (RX_READY === 1'b1) break;
		end
		RX_VALID <= 1'b0;
		RX_DATA <= ~b; // stale data would hide a late capture
	endtask
	task automatic t_cfg();
		`CHK("channel", 8'h00, CHANNEL);
		spi({OP_CFG_RD, CFG_CHANNEL}, 8'h00, 1);
		`CHK("cfg", 8'h00, resp[1]);
		spi({OP_CFG_WR, CFG_CHANNEL}, 8'h05, 2);
		`CHK("channel", 8'h05, CHANNEL);
		`CHK("rate", 8'h06, RATE);
		spi({OP_CFG_RD, CFG_CHANNEL}, 8'h00, 2);
		`CHK("cfg", 8'h06, resp[2]);
		$display("test cfg done");
	endtask
	task automatic t_cal();
		spi({OP_CMD, 1'b1, SUB_CAL}, 8'h00, 0);
		for (int i = 0; i < 100 && CAL_START !== 1'b1; i++) @(negedge CLOCK);
		`CHK("cal start", 1'b1, CAL_START);
		@(posedge CLOCK);
		CAL_CODE <= 4'ha;
		CAL_DONE <= 1'b1;
		@(posedge CLOCK);
		CAL_DONE <= 1'b0;
		repeat (6) @(negedge CLOCK);
		`CHK("tune", 4'ha, TUNE);
		`CHK("masked irq", 1'b0, IRQ);
		spi({OP_STAT_RD, 4'h0}, 8'h00, 1);
		`CHK("status", 8'(1 << EV_CAL), resp[1]);
		spi({OP_CFG_WR, CFG_IRQ_MASK}, 8'(1 << EV_CAL), 1);
		wait_irq(1'b1);
		repeat (20) @(negedge CLOCK);
		`CHK("irq held", 1'b1, IRQ);
		spi({OP_CMD, CMD_CLR_IRQ}, 8'h00, 0);
		wait_irq(1'b0);
		$display("test cal done");
	endtask
	task automatic t_init();
		spi({OP_CMD, 1'b1, SUB_INIT}, 8'h00, 0);
		wait_irq(1'b1);
		spi({OP_CFG_RD, CFG_TX_COUNT}, 8'h00, 2);
		`CHK("tx count", DEF_TX_COUNT, resp[1]);
		`CHK("rx count", DEF_RX_COUNT, resp[2]);
		`CHK("channel", 8'h00, CHANNEL);
		spi({OP_CMD, CMD_CLR_IRQ}, 8'h00, 0);
		wait_irq(1'b0);
		$display("test init done");
	endtask
	task automatic t_tx();
		spi({OP_TXB_WR, 4'h0}, 8'h01, FIFO_DEPTH + 1);
		spi({OP_STAT_RD, 4'h0}, 8'h00, 1);
		`CHK("overrun", 8'h10, resp[1]);
		spi({OP_CMD, 1'b1, SUB_SIMPLE}, 8'h00, 0);
		repeat (30) @(negedge CLOCK);
		`CHK("osc", 1'b1, OSC_ON);
		spi({OP_CMD, CMD_TRANSMIT}, 8'h00, 0);
		got = {};
		for (int i = 0; i < 300; i++) begin
			@(posedge CLOCK);
			if (TX_VALID === 1'b1 && TX_READY === 1'b1) got.push_back(TX_DATA);
			TX_READY <= (i % 3) != 0; // modulator stalls every third cycle
		end
		TX_READY <= 1'b0;
		`CHK("tx bytes", FIFO_DEPTH, got.size());
		for (int i = 0; i < got.size(); i++) `CHK("tx byte", 8'(i + 1), got[i]);
		@(negedge CLOCK);
		`CHK("sent irq", 1'b1, IRQ);
		`CHK("osc kept", 1'b1, OSC_ON);
		`CHK("synth", 1'b0, SYNTH_RX);
		spi({OP_CMD, CMD_CLR_IRQ}, 8'h00, 0);
		wait_irq(1'b0);
		$display("test tx done");
	endtask
	task automatic t_rx();
		spi({OP_CMD, 1'b1, SUB_RX_HDR}, 8'h00, 0);
		repeat (30) @(negedge CLOCK);
		`CHK("synth rx", 1'b1, SYNTH_RX);
		`CHK("rx enable", 1'b1, RX_ENABLE);
		`CHK("rx ready", 1'b1, RX_READY);
		put_rx(8'h02);
		put_rx(8'ha5);
		put_rx(8'h3c);
		wait_irq(1'b1);
		spi({OP_RXCNT_RD, 4'h0}, 8'h00, 1);
		`CHK("rx count", 8'h02, resp[1]);
		spi({OP_RXB_RD, 4'h0}, 8'h00, 3);
		`CHK("rx byte", 8'ha5, resp[1]);
		`CHK("rx byte", 8'h3c, resp[2]);
		`CHK("rx empty", 8'h00, resp[3]);
		spi({OP_CMD, CMD_STANDBY}, 8'h00, 0);
		`CHK("osc stop", 1'b0, OSC_ON);
		`CHK("synth stop", 1'b0, SYNTH_RX);
		// preset count of one: a header reading would drop the byte
		spi({OP_CFG_WR, CFG_RX_COUNT}, 8'h01, 1);
		spi({OP_CMD, 1'b1, SUB_RX_CNT}, 8'h00, 0);
		repeat (30) @(negedge CLOCK);
		put_rx(8'h77);
		repeat (4) @(negedge CLOCK);
		spi({OP_RXCNT_RD, 4'h0}, 8'h00, 1);
		`CHK("preset count", 8'h01, resp[1]);
		spi({OP_RXB_RD, 4'h0}, 8'h00, 1);
		`CHK("preset byte", 8'h77, resp[1]);
		$display("test rx done");
	endtask
	task automatic t_enable();
		@(posedge CLOCK);
		ENABLE <= 1'b0;
		repeat (8) @(negedge CLOCK);
		`CHK("irq off", 1'b0, IRQ);
		`CHK("osc off", 1'b0, OSC_ON);
		`CHK("synth off", 1'b0, SYNTH_RX);
		@(posedge CLOCK);
		ENABLE <= 1'b1;
		repeat (5) @(negedge CLOCK);
		spi({OP_CFG_RD, CFG_IRQ_MASK}, 8'h00, 1);
		`CHK("mask", 8'h00, resp[1]);
		$display("test enable done");
	endtask
	initial begin
		NRST = 1'b0;
		ENABLE = 1'b1;
		TX_READY = 1'b0;
		RX_DATA = 8'h00;
		RX_VALID = 1'b0;
		CAL_DONE = 1'b0;
		CAL_CODE = 4'h0;
		repeat (6) @(posedge CLOCK);
		NRST <= 1'b1;
		repeat (5) @(negedge CLOCK);
		t_cfg();
		t_cal();
		t_init();
		t_tx();
		t_rx();
		t_enable();
		finish_test();
	end
	// tests need about 4000 cycles
	initial begin
		repeat (30000) @(posedge CLOCK);
		errors++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
`default_nettype wire
